/* File: prefix_decode_consts.svh */
/*
  Constants for the wide-mode prefix and size decoder: prefix bytes,
  opcode classes, group-5 reg codes and widths.
  Assumes it is included by bare name from the package; the decoder uses its macros.
*/
`ifndef PREFIX_DECODE_CONSTS_SVH
`define PREFIX_DECODE_CONSTS_SVH

`define PFX_OPSIZE 8'h66
`define PFX_ADSIZE 8'h67
`define PFX_SEG_EXTRA 8'h26
`define PFX_SEG_CODE 8'h2e
`define PFX_SEG_STACK 8'h36
`define PFX_SEG_DATA 8'h3e
`define PFX_SEG_ONE 8'h64
`define PFX_SEG_TWO 8'h65
`define PFX_REGEXT_HI 4'h4
`define REGEXT_W_BIT 3
`define REGEXT_R_BIT 2
`define REGEXT_X_BIT 1
`define REGEXT_B_BIT 0
`define OPC_ESCAPE 8'h0f
`define OPC_ENTER 8'hc8
`define OPC_FRAME_DEL 8'hc9
`define OPC_POP_RM 8'h8f
`define OPC_POP_REG_HI 5'h0b
`define OPC_PUSH_REG_HI 5'h0a
`define OPC_POPF 8'h9d
`define OPC_PUSHF 8'h9c
`define OPC_PUSH_I32 8'h68
`define OPC_PUSH_I8 8'h6a
`define OPC_GRP5 8'hff
`define OPC_PUSH_SEG1 8'ha0
`define OPC_POP_SEG1 8'ha1
`define OPC_PUSH_SEG2 8'ha8
`define OPC_POP_SEG2 8'ha9
`define OPC_CALL_NEAR 8'he8
`define OPC_JMP_NEAR 8'he9
`define OPC_JMP_SHORT 8'heb
`define OPC_RET_NEAR 8'hc3
`define OPC_RET_IMM 8'hc2
`define OPC_LOOPNE 8'he0
`define OPC_LOOPE 8'he1
`define OPC_LOOP 8'he2
`define OPC_COPY_MOFFS_LO 8'ha0
`define OPC_COPY_MOFFS_HI 8'ha3
`define OPC_COPY_IMM_HI 5'h17
`define CREG_TASK_PRIO 4'h8
`define GRP5_CALL 3'h2
`define GRP5_JMP 3'h4
`define GRP5_PUSH 3'h6
`define MSR_ADDR_W 64
`define PHYS_ADDR_W 52

`endif

/* File: prefix_decode_pkg.sv */
/*
  Types for the wide-mode prefix and size decoder.
  Assumes the constants header is on the include path.
*/
package prefix_decode_pkg;
  `include "prefix_decode_consts.svh"

  // Processor operating mode as delivered by the mode logic
  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b00,
    MODE_COMPAT = 2'b01,
    MODE_WIDE = 2'b10
  } cpu_mode_t;

  // Operand or address size
  typedef enum logic [1:0] {
    SZ_8 = 2'b00,
    SZ_16 = 2'b01,
    SZ_32 = 2'b10,
    SZ_64 = 2'b11
  } size_t_t;

  // Segment base chosen for the address sum
  typedef enum logic [1:0] {
    SEG_NONE = 2'b00,
    SEG_ONE = 2'b01,
    SEG_TWO = 2'b10,
    SEG_LEGACY = 2'b11
  } seg_sel_t;

  // Decoder pipeline slot state
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_VALID = 1'b1
  } slot_state_t;
endpackage

/* File: wide_mode_prefix_size_decode.sv */
/*
  Wide-mode prefix and size decoder with address and result forming.
  Assumes fetch presents one instruction per valid cycle with prefixes
  already split out; execute ignores outputs while out_valid is low.
*/
// How it works
// - Model register physical addresses are read at full width.
// - Legacy mode reads and writes all implemented high model bits.
// - A meaningless extension prefix is ignored, no fault, no change.
// - In wide mode the extension prefix selects the task-priority register.
// - Near branches and stack-implicit ops default to 64-bit in wide mode.
// - Data, extra, stack, code overrides are null prefixes in wide mode.
// - Thread-base overrides add their segment base into the address.
// - Wide mode operand default is 32; extension width flag selects 64.
// - Wide-mode operand-size prefix selects 16 unless the width flag asks for 64.
// - Wide mode 32-bit register writes clear the upper 32 bits.
// - 8 and 16-bit register writes keep all higher destination bits.
// - Wide address default 64; prefix selects 32; no 16-bit addressing.
// - Compat and legacy address-size prefix toggles 16/32 against the segment default.
// - Displacements stay 32-bit, sign-extended, except wide copy forms.
// - Long mode addresses truncate to effective size, then zero-extend.
// - Relative address is next instruction pointer plus displacement.
// - Wide mode stack pushes and pops are 64 or 16-bit, never 32.
// - Enter, frame delete and the push/pop forms count as stack ops.
// - Wide mode has sixteen registers; the upper eight need extension.
// - Near call, jump and return are near branches defaulting to 64-bit.
`timescale 1ns/1ps
module wide_mode_prefix_size_decode
  import prefix_decode_pkg::*;
#(
  parameter int MSR_W = `MSR_ADDR_W,
  parameter int PA_W = `PHYS_ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire cpu_mode_t mode,
  input wire logic seg_default_32,
  input wire logic has_opsize_pfx,
  input wire logic has_adsize_pfx,
  input wire logic [7:0] seg_pfx,
  input wire logic has_seg_pfx,
  input wire logic has_regext_pfx,
  input wire logic [3:0] regext_bits,
  input wire logic [7:0] opcode,
  input wire logic escaped,
  input wire logic [2:0] modrm_reg,
  input wire logic byte_op,
  input wire logic rip_rel,
  input wire logic [63:0] ea_raw,
  input wire logic [31:0] disp32,
  input wire logic [63:0] imm64,
  input wire logic [63:0] next_instr_pointer,
  input wire logic [63:0] seg_base_one,
  input wire logic [63:0] seg_base_two,
  input wire logic [31:0] seg_base_legacy,
  input wire logic [63:0] result,
  input wire logic [63:0] dest_old,
  input wire logic msr_wr,
  input wire logic [MSR_W-1:0] msr_wdata,
  output logic out_valid,
  output size_t_t op_size,
  output size_t_t addr_size,
  output logic stack_op,
  output logic near_branch,
  output seg_sel_t seg_sel,
  output logic [3:0] reg_dst_idx,
  output logic task_prio_sel,
  output logic [63:0] eff_addr,
  output logic [63:0] reg_wdata,
  output logic [MSR_W-1:0] msr_rdata,
  output logic [63:0] msr_phys_addr
);

  // Mode decode; wide-mode meanings hang off this one wire
  wire wide = (mode == MODE_WIDE);
  wire rex_live = wide && has_regext_pfx;
  wire rex_w = rex_live && regext_bits[`REGEXT_W_BIT];

  // Opcode classes
  wire grp5 = !escaped && (opcode == `OPC_GRP5);
  wire is_stack_plain = !escaped && (
    (opcode == `OPC_ENTER) || (opcode == `OPC_FRAME_DEL) ||
    (opcode == `OPC_POP_RM) || (opcode[7:3] == `OPC_POP_REG_HI) ||
    (opcode[7:3] == `OPC_PUSH_REG_HI) || (opcode == `OPC_POPF) ||
    (opcode == `OPC_PUSHF) || (opcode == `OPC_PUSH_I32) ||
    (opcode == `OPC_PUSH_I8) ||
    (grp5 && modrm_reg == `GRP5_PUSH));
  wire is_stack_esc = escaped && (
    (opcode == `OPC_PUSH_SEG1) || (opcode == `OPC_POP_SEG1) ||
    (opcode == `OPC_PUSH_SEG2) || (opcode == `OPC_POP_SEG2));
  wire is_stack = is_stack_plain || is_stack_esc;
  wire is_near = !escaped && (
    (opcode == `OPC_CALL_NEAR) || (opcode == `OPC_JMP_NEAR) ||
    (opcode == `OPC_JMP_SHORT) || (opcode == `OPC_RET_NEAR) ||
    (opcode == `OPC_RET_IMM) || (opcode == `OPC_LOOP) ||
    (opcode == `OPC_LOOPE) || (opcode == `OPC_LOOPNE) ||
    (grp5 && (modrm_reg == `GRP5_CALL || modrm_reg == `GRP5_JMP)) ||
    (opcode[7:4] == 4'h7)) ||
    (escaped && opcode[7:4] == 4'h8);
  wire is_copy_wide = !escaped && wide && (
    ((opcode >= `OPC_COPY_MOFFS_LO) && (opcode <= `OPC_COPY_MOFFS_HI)) ||
    (rex_w && opcode[7:3] == `OPC_COPY_IMM_HI));
  wire is_creg_move = escaped && (opcode == 8'h20 || opcode == 8'h22);

  // Operand size: default 64 for stack and near branch, 16 by override
  size_t_t op_nxt;
  always_comb begin
    if (byte_op) begin
      op_nxt = SZ_8;
    end else if (wide && (is_stack || is_near)) begin
      // Width flag outranks the operand-size prefix here as well
      op_nxt = (has_opsize_pfx && !rex_w) ? SZ_16 :
        SZ_64;
    end else if (rex_w) begin
      op_nxt = SZ_64;
    end else if (wide) begin
      op_nxt = has_opsize_pfx ? SZ_16 : SZ_32;
    end else begin
      op_nxt = (has_opsize_pfx ^ seg_default_32) ? SZ_32 : SZ_16;
    end
  end

  // Address size: wide has 64/32 only, others follow legacy toggling
  wire size_t_t ad_nxt = wide ? (has_adsize_pfx ? SZ_32 : SZ_64) :
    ((has_adsize_pfx ^ seg_default_32) ? SZ_32 : SZ_16);

  // Segment override; four legacy overrides become null in wide mode
  wire seg_one = has_seg_pfx && (seg_pfx == `PFX_SEG_ONE);
  wire seg_two = has_seg_pfx && (seg_pfx == `PFX_SEG_TWO);
  wire seg_null_wide = has_seg_pfx && !seg_one && !seg_two;
  wire seg_sel_t seg_nxt = seg_one ? SEG_ONE : seg_two ? SEG_TWO :
    (seg_null_wide && !wide) ? SEG_LEGACY : SEG_NONE;

  // Register extension: unused bits simply drop out, never fault
  wire [3:0] dst_nxt = {rex_live && regext_bits[`REGEXT_R_BIT],
    modrm_reg};
  wire tpr_nxt = is_creg_move && rex_live &&
    regext_bits[`REGEXT_R_BIT] && (modrm_reg == 3'h0);

  // Displacement sign-extends; only the wide copy forms carry 64 bits
  wire [63:0] disp_ext = is_copy_wide ? imm64 :
    {{32{disp32[31]}}, disp32};
  wire [63:0] base_sum = rip_rel && wide ?
    next_instr_pointer + disp_ext : ea_raw + disp_ext;
  wire [63:0] seg_add = (seg_nxt == SEG_ONE) ?
    (wide ? seg_base_one : {32'h0, seg_base_one[31:0]}) :
    (seg_nxt == SEG_TWO) ?
    (wide ? seg_base_two : {32'h0, seg_base_two[31:0]}) :
    (!wide ? {32'h0, seg_base_legacy} : 64'h0);

  // Truncate to effective size first, then zero-extend the result
  wire [63:0] off_trunc = (ad_nxt == SZ_64) ? base_sum :
    (ad_nxt == SZ_32) ? {32'h0, base_sum[31:0]} :
    {48'h0, base_sum[15:0]};
  // Outside wide mode the 16-bit offset wraps before the base is added,
  // and the linear sum itself wraps at 32 bits
  wire [63:0] ea_nxt = wide ? off_trunc + seg_add :
    {32'h0, off_trunc[31:0] + seg_add[31:0]};

  // Register write merge; narrow writes keep their upper bits
  logic [63:0] wb_nxt;
  always_comb begin
    case (op_nxt)
      SZ_8: wb_nxt = {dest_old[63:8], result[7:0]};
      SZ_16: wb_nxt = {dest_old[63:16], result[15:0]};
      SZ_32: wb_nxt = wide ? {32'h0, result[31:0]} :
        {dest_old[63:32], result[31:0]};
      SZ_64: wb_nxt = result;
      default: wb_nxt = dest_old;
    endcase
  end

  // Model register store keeps all implemented bits in every mode; unimplemented
  // bits above the physical width stay zero so readback is honest
  localparam logic [MSR_W-1:0] MSR_IMPL = {{(MSR_W-PA_W){1'b0}},
    {PA_W{1'b1}}};
  logic [MSR_W-1:0] msr_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      msr_r <= '0;
    end else if (msr_wr) begin
      msr_r <= msr_wdata & MSR_IMPL;
    end
  end

  // Output slot; one-cycle decode latency
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op_size <= SZ_32;
      addr_size <= SZ_32;
      stack_op <= 1'b0;
      near_branch <= 1'b0;
      seg_sel <= SEG_NONE;
      reg_dst_idx <= 4'h0;
      task_prio_sel <= 1'b0;
      eff_addr <= 64'h0;
      reg_wdata <= 64'h0;
    end else if (in_valid) begin
      op_size <= op_nxt;
      addr_size <= ad_nxt;
      stack_op <= is_stack;
      near_branch <= is_near;
      seg_sel <= seg_nxt;
      reg_dst_idx <= dst_nxt;
      task_prio_sel <= tpr_nxt;
      eff_addr <= ea_nxt;
      reg_wdata <= wb_nxt;
    end
  end

  // Registered model-register views; full width regardless of mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      msr_rdata <= '0;
      msr_phys_addr <= 64'h0;
    end else begin
      msr_rdata <= msr_r;
      msr_phys_addr <= 64'(msr_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
    end
  end

endmodule

/* File: prefix_decode_checker.sv */
/* Port checker for the wide-mode decoder.
   Assumes each answer lands exactly one cycle after its request. */
`timescale 1ns/1ps
module prefix_decode_checker
  import prefix_decode_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire cpu_mode_t mode,
  input wire logic has_opsize_pfx,
  input wire logic has_adsize_pfx,
  input wire logic has_regext_pfx,
  input wire logic [3:0] regext_bits,
  input wire logic [7:0] opcode,
  input wire logic escaped,
  input wire logic byte_op,
  input wire logic [63:0] result,
  input wire logic [63:0] dest_old,
  input wire logic out_valid,
  input wire size_t_t op_size,
  input wire size_t_t addr_size,
  input wire logic stack_op,
  input wire logic near_branch,
  input wire logic [63:0] reg_wdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Shorthands; plain is a one-byte ALU opcode in wide mode
  wire wide = in_valid && mode == MODE_WIDE;
  wire rex_w = has_regext_pfx && regext_bits[3];
  wire plain = wide && !escaped && !byte_op && opcode == 8'h01;
  a_valid_follow: assert property ($past(!rst) |-> out_valid == $past(in_valid))
    else $error("out_valid does not trail in_valid");
  a_opsize_dflt: assert property (
    plain && !has_opsize_pfx && !rex_w |=> op_size == SZ_32)
    else $error("wide default operand size wrong");
  a_opsize_rexw: assert property (
    plain && rex_w |=> op_size == SZ_64) else $error("width flag lost");
  a_stack_size: assert property (
    wide && !escaped && opcode[7:3] == 5'h0a |=> stack_op && op_size ==
    ($past(has_opsize_pfx && !rex_w) ? SZ_16 : SZ_64))
    else $error("stack push size wrong");
  a_near_call: assert property (
    wide && !escaped && !has_opsize_pfx && opcode == 8'he8 |=>
    near_branch && op_size == SZ_64) else $error("near call size wrong");
  a_addr_wide: assert property (
    plain |=> addr_size == ($past(has_adsize_pfx) ? SZ_32 : SZ_64))
    else $error("wide address size wrong");
  a_zero_ext: assert property (
    plain |=> op_size != SZ_32 || reg_wdata == {32'h0, $past(result[31:0])})
    else $error("upper half not cleared");
  a_byte_keep: assert property (
    wide && byte_op && has_regext_pfx |=>
    reg_wdata == {$past(dest_old[63:8]), $past(result[7:0])})
    else $error("byte write disturbed upper bits");
endmodule
bind wide_mode_prefix_size_decode prefix_decode_checker i_chk (.ref_clk, .rst,
  .in_valid, .mode, .has_opsize_pfx, .has_adsize_pfx, .has_regext_pfx,
  .regext_bits, .opcode, .escaped, .byte_op, .result, .dest_old, .out_valid,
  .op_size, .addr_size, .stack_op, .near_branch, .reg_wdata);

/* File: exec_sink.sv */
/* Execute-side sink: takes each one-cycle answer of the decoder.
   Assumes out_valid stands one cycle per taken instruction. */
`timescale 1ns/1ps
module exec_sink (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic out_valid,
  input wire logic [63:0] eff_addr,
  output logic [15:0] n_taken,
  output logic [63:0] cap_ea
);
  // Only the valid cycle is consumed, so a stale answer shows as a miss
  always @(posedge ref_clk) begin
    if (rst) begin
      n_taken <= 16'h0;
    end else if (out_valid) begin
      n_taken <= n_taken + 16'h1;
      cap_ea <= eff_addr;
    end
  end
endmodule

/* File: test_wide_mode_prefix_size_decode.sv */
/* Self-checking bench for the wide-mode decoder.
   Assumes answers one cycle after each edge with in_valid high. */
`timescale 1ns/1ps
module test_wide_mode_prefix_size_decode
  import prefix_decode_pkg::*;
;
  typedef struct packed {
    cpu_mode_t m; logic o; logic [3:0] x; logic e; logic [7:0] c;
    size_t_t s; logic k; logic n;
  } row_t;
  logic ref_clk = 0, rst = 1, in_valid = 0, msr_wr = 0, seg_default_32;
  logic has_opsize_pfx, has_adsize_pfx, has_seg_pfx, has_regext_pfx;
  logic escaped, byte_op, rip_rel, out_valid, stack_op, near_branch;
  logic task_prio_sel;
  cpu_mode_t mode;
  size_t_t op_size, addr_size;
  seg_sel_t seg_sel;
  logic [7:0] seg_pfx, opcode;
  logic [3:0] regext_bits, reg_dst_idx;
  logic [2:0] modrm_reg;
  logic [15:0] n_out;
  logic [31:0] disp32, seg_base_legacy;
  logic [63:0] ea_raw, imm64, next_instr_pointer, seg_base_one, seg_base_two;
  logic [63:0] result, dest_old, msr_wdata, eff_addr, reg_wdata, msr_rdata;
  logic [63:0] msr_phys_addr, cap_ea;
  int fails = 0, comparisons = 0, cyc = 0;
  // Mode, 66h, extension bits, escape, opcode, size, stack, near
  row_t rows [16] = '{
    '{MODE_WIDE, '0, 4'h0, '0, 8'h01, SZ_32, '0, '0},
    '{MODE_WIDE, '0, 4'h8, '0, 8'h01, SZ_64, '0, '0},
    '{MODE_WIDE, '1, 4'h0, '0, 8'h01, SZ_16, '0, '0},
    '{MODE_WIDE, '1, 4'h8, '0, 8'h01, SZ_64, '0, '0},
    '{MODE_WIDE, '0, 4'h4, '0, 8'h01, SZ_32, '0, '0},
    '{MODE_WIDE, '0, 4'h0, '0, 8'h50, SZ_64, '1, '0},
    '{MODE_WIDE, '1, 4'h0, '0, 8'h5f, SZ_16, '1, '0},
    '{MODE_WIDE, '1, 4'h8, '0, 8'h57, SZ_64, '1, '0},
    '{MODE_WIDE, '0, 4'h0, '0, 8'hc9, SZ_64, '1, '0},
    '{MODE_WIDE, '0, 4'h0, '0, 8'h68, SZ_64, '1, '0},
    '{MODE_WIDE, '0, 4'h0, '1, 8'ha9, SZ_64, '1, '0},
    '{MODE_WIDE, '0, 4'h0, '0, 8'he8, SZ_64, '0, '1},
    '{MODE_WIDE, '0, 4'h0, '0, 8'hc3, SZ_64, '0, '1},
    '{MODE_COMPAT, '0, 4'h0, '0, 8'h01, SZ_32, '0, '0},
    '{MODE_COMPAT, '1, 4'h0, '0, 8'h01, SZ_16, '0, '0},
    '{MODE_LEGACY, '1, 4'h0, '0, 8'h01, SZ_16, '0, '0}};
  wide_mode_prefix_size_decode i_dut (.ref_clk, .rst, .in_valid, .mode,
    .seg_default_32, .has_opsize_pfx, .has_adsize_pfx, .seg_pfx, .has_seg_pfx,
    .has_regext_pfx, .regext_bits, .opcode, .escaped, .modrm_reg, .byte_op,
    .rip_rel, .ea_raw, .disp32, .imm64, .next_instr_pointer, .seg_base_one,
    .seg_base_two, .seg_base_legacy, .result, .dest_old, .msr_wr, .msr_wdata,
    .out_valid, .op_size, .addr_size, .stack_op, .near_branch, .seg_sel,
    .reg_dst_idx, .task_prio_sel, .eff_addr, .reg_wdata, .msr_rdata,
    .msr_phys_addr);
  exec_sink i_sink (.ref_clk, .rst, .out_valid, .eff_addr, .n_taken(n_out),
    .cap_ea);
  always #2.5 ref_clk = ~ref_clk;
  // Hang guard, far above the 37 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      report_and_stop;
    end
  end
  task step;
    @(posedge ref_clk) #1;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task clr;
    {has_opsize_pfx, has_adsize_pfx, has_seg_pfx, has_regext_pfx} = 4'h0;
    {escaped, byte_op, rip_rel, seg_default_32} = 4'h1;
    {seg_pfx, opcode, regext_bits, modrm_reg} = 23'h0;
    {disp32, seg_base_legacy, ea_raw, imm64, next_instr_pointer} = '0;
    {seg_base_one, seg_base_two, result, dest_old, msr_wdata} = '0;
    mode = MODE_WIDE;
  endtask
  task report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Reset, the row table, then hand-written awkward cases
  initial begin
    clr;
    repeat (5) step;
    chk(out_valid, 0);
    chk(op_size, SZ_32);
    rst = 0;
    in_valid = 1;
    foreach (rows[i]) begin
      mode = rows[i].m;
      {has_opsize_pfx, regext_bits} = {rows[i].o, rows[i].x};
      {escaped, opcode, has_regext_pfx} = {rows[i].e, rows[i].c, |rows[i].x};
      step;
      chk(op_size, rows[i].s);
      chk(stack_op, rows[i].k);
      chk(near_branch, rows[i].n);
    end
    $display("table done");
    clr;
    rip_rel = 1;
    next_instr_pointer = 64'h7fff_ffff_fff0;
    disp32 = 32'hffff_ff00;
    step;
    step;
    chk(cap_ea, 64'h7fff_ffff_fef0);
    {rip_rel, has_adsize_pfx, disp32} = {2'b01, 32'h20};
    ea_raw = 64'h1234_5678_ffff_fff0;
    step;
    chk(eff_addr, 64'h10);
    {has_adsize_pfx, has_seg_pfx, seg_pfx, disp32} = {2'b01, 8'h65, 32'h0};
    seg_base_two = 64'h1000_0000_0000;
    {ea_raw, seg_base_legacy} = {64'h40, 32'h5000};
    step;
    chk(eff_addr, 64'h1000_0000_0040);
    chk(seg_sel, SEG_TWO);
    seg_pfx = 8'h3e;
    step;
    chk(eff_addr, 64'h40);
    chk(seg_sel, SEG_NONE);
    mode = MODE_LEGACY;
    {has_adsize_pfx, ea_raw} = {1'b1, 64'h3_0040};
    step;
    chk(addr_size, SZ_16);
    chk(eff_addr, 64'h5040);
    chk(seg_sel, SEG_LEGACY);
    clr;
    {opcode, result} = {8'h01, 64'hffff_ffff_8000_0001};
    dest_old = 64'haaaa_aaaa_aaaa_aaaa;
    step;
    chk(reg_wdata, 64'h8000_0001);
    has_opsize_pfx = 1;
    step;
    chk(reg_wdata, 64'haaaa_aaaa_aaaa_0001);
    {has_opsize_pfx, byte_op, has_regext_pfx} = 3'b011;
    step;
    chk(reg_wdata, 64'haaaa_aaaa_aaaa_aa01);
    clr;
    {escaped, opcode, has_regext_pfx, regext_bits} = {1'b1, 8'h22, 1'b1, 4'h4};
    step;
    chk(task_prio_sel, 1);
    chk(reg_dst_idx, 4'h8);
    in_valid = 0;
    mode = MODE_LEGACY;
    {msr_wr, msr_wdata} = {1'b1, 64'hfedc_ba98_7654_3210};
    step;
    msr_wr = 0;
    repeat (3) step;
    chk(msr_rdata, 64'h000c_ba98_7654_3210);
    chk(msr_phys_addr, 64'h000c_ba98_7654_3210);
    chk(out_valid, 0);
    chk(n_out, 16'd26);
    // Mid-run reset with a request standing: reset must win
    {rst, in_valid} = 2'b11;
    step;
    chk(out_valid, 0);
    chk(addr_size, SZ_32);
    chk(msr_phys_addr, 64'h0);
    rst = 0;
    step;
    chk(out_valid, 1);
    $display("hand cases done");
    report_and_stop;
  end
endmodule
